// ==== rtl/pomc_defines.vh ====
// constants of the output modulation control block
`ifndef POMC_DEFINES_VH
`define POMC_DEFINES_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define POMC_ADDR_W        12
`define POMC_ADDR_MOD      12'h000
`define POMC_ADDR_TRAP     12'h004
`define POMC_ADDR_STAT     12'h008
`define POMC_ADDR_IRQ_ST   12'h00C
`define POMC_ADDR_IRQ_MSK  12'h010

// ---------------------------------------------------------------
// modulation control fields
// ---------------------------------------------------------------
`define POMC_MOD_A_LSB     0
`define POMC_MOD_A_MSB     5
`define POMC_MOD_RSVD_LO   6
`define POMC_MOD_MCM_EN    7
`define POMC_MOD_B_LSB     8
`define POMC_MOD_B_MSB     13
`define POMC_MOD_RSVD_HI   14
`define POMC_MOD_XOUT_EN   15
`define POMC_MOD_RESET     16'h0000

// ---------------------------------------------------------------
// trap control fields
// ---------------------------------------------------------------
`define POMC_TRP_SYNC_LSB  0
`define POMC_TRP_SYNC_MSB  1
`define POMC_TRP_SW_EXIT   2
`define POMC_TRP_EN_LSB    8
`define POMC_TRP_EN_MSB    13
`define POMC_TRP_XOUT_EN   14
`define POMC_TRP_PIN_EN    15
`define POMC_TRP_RESET     16'h0000

// trap exit synchronisation codes
`define POMC_SYNC_TA_ZERO  2'h0
`define POMC_SYNC_TB_ZERO  2'h1
`define POMC_SYNC_RSVD     2'h2
`define POMC_SYNC_NONE     2'h3

// ---------------------------------------------------------------
// status and interrupt fields
// ---------------------------------------------------------------
`define POMC_ST_FLAG       0
`define POMC_ST_STATE      1
`define POMC_IRQ_ENTER     0
`define POMC_IRQ_LEAVE     1
`define POMC_IRQ_W         2
`define POMC_IRQ_RESET     2'h0

`endif

// ==== rtl/pomc_apb_slave.v ====
// apb slave front end: phase tracking, strobes, registered answer
`timescale 1ns/1ns
`default_nettype none

module pomc_apb_slave (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] rdata_i,
    input  wire        hit_i,
    output wire        wr_o,
    output wire        rd_o,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o
);

    wire setup;

    // ---------------------------------------------------------------
    // phase decode
    // ---------------------------------------------------------------
    // answer is prepared in setup, so access always ends in one cycle
    assign setup = psel_i & ~penable_i;
    assign wr_o  = psel_i & penable_i & pready_o & pwrite_i;
    assign rd_o  = psel_i & penable_i & pready_o & ~pwrite_i;

    // ---------------------------------------------------------------
    // answer registers
    // ---------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup & ~hit_i;
            if (setup & ~pwrite_i) begin
                prdata_o <= hit_i ? rdata_i : 32'h00000000;
            end
        end
    end

endmodule // pomc_apb_slave

`default_nettype wire

// ==== rtl/pomc_top.v ====
// output modulation and trap entry logic of the six-output compare unit
`timescale 1ns/1ns
`default_nettype none
`include "pomc_defines.vh"

module pomc_top (
    input  wire        clk_i,
    input  wire        rst_i,
    // apb
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // patterns, one bit per output
    input  wire [5:0]  timer_a_pattern_i,
    input  wire [5:0]  timer_b_pattern_i,
    input  wire [5:0]  multichannel_pattern_field_i,
    input  wire        timer_b_signal_i,
    // trap exit synchronisation events
    input  wire        timer_a_zero_match_i,
    input  wire        timer_b_zero_match_i,
    // trap pin, active low
    input  wire        trap_input_pin_n_i,
    // outputs
    output reg         channel0_compare_out_o,
    output reg         channel0_complement_out_o,
    output reg         channel1_compare_out_o,
    output reg         channel1_complement_out_o,
    output reg         channel2_compare_out_o,
    output reg         channel2_complement_out_o,
    output reg         timer_b_extra_out_o,
    output reg         trap_state_o,
    output reg         irq_o
);

    // ---------------------------------------------------------------
    // registers and wires
    // ---------------------------------------------------------------
    reg  [5:0]  timer_a_modulation_mask_q;
    reg         multichannel_modulation_enable_q;
    reg  [5:0]  timer_b_modulation_mask_q;
    reg         timer_b_extra_output_enable_q;

    reg  [1:0]  trap_sync_q;
    reg         trap_exit_mode_select_q;
    reg  [5:0]  trap_out_en_q;
    reg         trap_xout_en_q;
    reg         trap_pin_en_q;

    reg         trap_flag_q;
    reg         trap_flag_d;
    reg         trap_state_q;
    reg         trap_state_d;

    reg  [1:0]  irq_status_q;
    reg  [1:0]  irq_status_d;
    reg  [1:0]  irq_mask_q;

    reg  [31:0] rdata;
    reg         hit;
    reg         sync_seen;

    wire        wr;
    wire        rd;
    wire        sel_mod;
    wire        sel_trap;
    wire        sel_stat;
    wire        sel_irq_st;
    wire        sel_irq_msk;
    wire        trap_cond;
    wire [5:0]  out_d;
    wire        xout_d;
    wire [1:0]  irq_event;

    // reset images of both control words, sliced per field
    localparam [15:0] MOD_RST = `POMC_MOD_RESET;
    localparam [15:0] TRP_RST = `POMC_TRP_RESET;

    // ---------------------------------------------------------------
    // bus front end
    // ---------------------------------------------------------------
    pomc_apb_slave u_apb (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .rdata_i   (rdata),
        .hit_i     (hit),
        .wr_o      (wr),
        .rd_o      (rd),
        .prdata_o  (prdata_o),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o)
    );

    assign sel_mod     = (paddr_i == `POMC_ADDR_MOD);
    assign sel_trap    = (paddr_i == `POMC_ADDR_TRAP);
    assign sel_stat    = (paddr_i == `POMC_ADDR_STAT);
    assign sel_irq_st  = (paddr_i == `POMC_ADDR_IRQ_ST);
    assign sel_irq_msk = (paddr_i == `POMC_ADDR_IRQ_MSK);

    always @* begin
        hit = sel_mod | sel_trap | sel_stat | sel_irq_st | sel_irq_msk;
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always @* begin
        rdata = 32'h00000000;
        if (sel_mod) begin
            rdata[`POMC_MOD_A_MSB:`POMC_MOD_A_LSB] = timer_a_modulation_mask_q;
            rdata[`POMC_MOD_RSVD_LO] = 1'b0;
            rdata[`POMC_MOD_MCM_EN] = multichannel_modulation_enable_q;
            rdata[`POMC_MOD_B_MSB:`POMC_MOD_B_LSB] = timer_b_modulation_mask_q;
            rdata[`POMC_MOD_RSVD_HI] = 1'b0;
            rdata[`POMC_MOD_XOUT_EN] = timer_b_extra_output_enable_q;
        end
        if (sel_trap) begin
            rdata[`POMC_TRP_SYNC_MSB:`POMC_TRP_SYNC_LSB] = trap_sync_q;
            rdata[`POMC_TRP_SW_EXIT] = trap_exit_mode_select_q;
            rdata[`POMC_TRP_EN_MSB:`POMC_TRP_EN_LSB] = trap_out_en_q;
            rdata[`POMC_TRP_XOUT_EN] = trap_xout_en_q;
            rdata[`POMC_TRP_PIN_EN] = trap_pin_en_q;
        end
        if (sel_stat) begin
            rdata[`POMC_ST_FLAG] = trap_flag_q;
            rdata[`POMC_ST_STATE] = trap_state_q;
        end
        if (sel_irq_st) begin
            rdata[`POMC_IRQ_W-1:0] = irq_status_q;
        end
        if (sel_irq_msk) begin
            rdata[`POMC_IRQ_W-1:0] = irq_mask_q;
        end
    end

    // ---------------------------------------------------------------
    // modulation control register
    // ---------------------------------------------------------------
    // reserved bit 6 of each byte is simply not stored
    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_a_modulation_mask_q        <= MOD_RST[`POMC_MOD_A_MSB:`POMC_MOD_A_LSB];
            multichannel_modulation_enable_q <= MOD_RST[`POMC_MOD_MCM_EN];
            timer_b_modulation_mask_q        <= MOD_RST[`POMC_MOD_B_MSB:`POMC_MOD_B_LSB];
            timer_b_extra_output_enable_q    <= MOD_RST[`POMC_MOD_XOUT_EN];
        end else if (wr && sel_mod) begin
            timer_a_modulation_mask_q <=
                pwdata_i[`POMC_MOD_A_MSB:`POMC_MOD_A_LSB];
            multichannel_modulation_enable_q <=
                pwdata_i[`POMC_MOD_MCM_EN];
            timer_b_modulation_mask_q <=
                pwdata_i[`POMC_MOD_B_MSB:`POMC_MOD_B_LSB];
            timer_b_extra_output_enable_q <=
                pwdata_i[`POMC_MOD_XOUT_EN];
        end
    end

    // ---------------------------------------------------------------
    // trap control register
    // ---------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            trap_sync_q             <= TRP_RST[`POMC_TRP_SYNC_MSB:`POMC_TRP_SYNC_LSB];
            trap_exit_mode_select_q <= TRP_RST[`POMC_TRP_SW_EXIT];
            trap_out_en_q           <= TRP_RST[`POMC_TRP_EN_MSB:`POMC_TRP_EN_LSB];
            trap_xout_en_q          <= TRP_RST[`POMC_TRP_XOUT_EN];
            trap_pin_en_q           <= TRP_RST[`POMC_TRP_PIN_EN];
        end else if (wr && sel_trap) begin
            trap_sync_q <=
                pwdata_i[`POMC_TRP_SYNC_MSB:`POMC_TRP_SYNC_LSB];
            trap_exit_mode_select_q <= pwdata_i[`POMC_TRP_SW_EXIT];
            trap_out_en_q <=
                pwdata_i[`POMC_TRP_EN_MSB:`POMC_TRP_EN_LSB];
            trap_xout_en_q <= pwdata_i[`POMC_TRP_XOUT_EN];
            trap_pin_en_q  <= pwdata_i[`POMC_TRP_PIN_EN];
        end
    end

    // ---------------------------------------------------------------
    // trap flag and trap state
    // ---------------------------------------------------------------
    // pin gated by its enable, so a floating pin cannot trap at boot
    assign trap_cond = trap_pin_en_q & ~trap_input_pin_n_i;

    always @* begin
        // code 2 is reserved: no event, so the trap state holds
        case (trap_sync_q)
            `POMC_SYNC_TA_ZERO: sync_seen = timer_a_zero_match_i;
            `POMC_SYNC_TB_ZERO: sync_seen = timer_b_zero_match_i;
            `POMC_SYNC_NONE:    sync_seen = 1'b1;
            default:            sync_seen = 1'b0;
        endcase
    end

    always @* begin
        trap_flag_d = trap_flag_q;
        if (trap_cond) begin
            // pin low wins over any clear
            trap_flag_d = 1'b1;
        end else if (!trap_exit_mode_select_q) begin
            trap_flag_d = 1'b0;
        end else if (wr && sel_stat && pwdata_i[`POMC_ST_FLAG]) begin
            // software exit: a written one clears, unless the pin is enabled and low
            trap_flag_d = 1'b0;
        end
    end

    always @* begin
        trap_state_d = trap_state_q;
        if (trap_flag_q) begin
            trap_state_d = 1'b1;
        end else if (sync_seen) begin
            trap_state_d = 1'b0;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            trap_flag_q  <= 1'b0;
            trap_state_q <= 1'b0;
        end else begin
            trap_flag_q  <= trap_flag_d;
            trap_state_q <= trap_state_d;
        end
    end

    // ---------------------------------------------------------------
    // interrupt status and mask
    // ---------------------------------------------------------------
    assign irq_event[`POMC_IRQ_ENTER] = trap_state_d & ~trap_state_q;
    assign irq_event[`POMC_IRQ_LEAVE] = ~trap_state_d & trap_state_q;

    always @* begin
        irq_status_d = irq_status_q;
        if (wr && sel_irq_st) begin
            irq_status_d = irq_status_q & ~pwdata_i[`POMC_IRQ_W-1:0];
        end
        // a new event beats a clear in the same cycle
        irq_status_d = irq_status_d | irq_event;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_q <= `POMC_IRQ_RESET;
            irq_mask_q   <= `POMC_IRQ_RESET;
            irq_o        <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            if (wr && sel_irq_msk) begin
                irq_mask_q <= pwdata_i[`POMC_IRQ_W-1:0];
            end
            // a mask written now counts at once, no stale request
            irq_o <= |(irq_status_d & ((wr && sel_irq_msk) ?
                     pwdata_i[`POMC_IRQ_W-1:0] : irq_mask_q));
        end
    end

    // ---------------------------------------------------------------
    // per-output modulation
    // ---------------------------------------------------------------
    // index order: 0 ch0 cmp, 1 ch0 comp, 2 ch1 cmp,
    // 3 ch1 comp, 4 ch2 cmp, 5 ch2 comp
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_out
            wire en_a;
            wire en_b;
            wire en_m;
            wire any_en;
            wire level;
            assign en_a = timer_a_modulation_mask_q[g];
            assign en_b = timer_b_modulation_mask_q[g];
            assign en_m = multichannel_modulation_enable_q;
            assign any_en = en_a | en_b | en_m;
            // disabled sources pass through as one; all active ands
            assign level = any_en &
                           (~en_a | timer_a_pattern_i[g]) &
                           (~en_b | timer_b_pattern_i[g]) &
                           (~en_m | multichannel_pattern_field_i[g]);
            // trap forces passive low only on trap-enabled outputs
            assign out_d[g] = level & ~(trap_state_d & trap_out_en_q[g]);
        end
    endgenerate

    // extra output has its own trap enable, apart from the six
    assign xout_d = timer_b_extra_output_enable_q & timer_b_signal_i &
                    ~(trap_state_d & trap_xout_en_q);

    // ---------------------------------------------------------------
    // output flops
    // ---------------------------------------------------------------
    // trap decision uses the next state, so forced levels reach pins on the same edge as trap_state_o, two edges after the pin
    always @(posedge clk_i) begin
        if (rst_i) begin
            channel0_compare_out_o    <= 1'b0;
            channel0_complement_out_o <= 1'b0;
            channel1_compare_out_o    <= 1'b0;
            channel1_complement_out_o <= 1'b0;
            channel2_compare_out_o    <= 1'b0;
            channel2_complement_out_o <= 1'b0;
            timer_b_extra_out_o       <= 1'b0;
            trap_state_o              <= 1'b0;
        end else begin
            channel0_compare_out_o    <= out_d[0];
            channel0_complement_out_o <= out_d[1];
            channel1_compare_out_o    <= out_d[2];
            channel1_complement_out_o <= out_d[3];
            channel2_compare_out_o    <= out_d[4];
            channel2_complement_out_o <= out_d[5];
            timer_b_extra_out_o       <= xout_d;
            trap_state_o              <= trap_state_d;
        end
    end

endmodule // pomc_top

`default_nettype wire

// ==== bench/pomc_stage_model.sv ====
// power stage and trap source model at the far side of the block
`timescale 1ns/1ns
`default_nettype none
module pomc_stage_model (
    input  wire logic       clk_i,
    input  wire logic       pull_i,
    input  wire logic [6:0] drive_i,
    output var  logic       trap_input_pin_n_o
);
    // pin has a pull-up: released means high
    initial trap_input_pin_n_o = 1'b1;
    always @(posedge clk_i) begin
        trap_input_pin_n_o <= !pull_i;
    end
endmodule // pomc_stage_model
`default_nettype wire

// ==== bench/pomc_top_monitor.sv ====
// port checker of modulation levels, trap entry and exit, apb answer
`timescale 1ns/1ns
`default_nettype none
`include "pomc_defines.vh"
module pomc_top_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [5:0]  timer_a_pattern_i,
    input wire logic [5:0]  timer_b_pattern_i,
    input wire logic [5:0]  multichannel_pattern_field_i,
    input wire logic        timer_b_signal_i,
    input wire logic        timer_a_zero_match_i,
    input wire logic        timer_b_zero_match_i,
    input wire logic        trap_input_pin_n_i,
    input wire logic        channel0_compare_out_o,
    input wire logic        channel0_complement_out_o,
    input wire logic        channel1_compare_out_o,
    input wire logic        channel1_complement_out_o,
    input wire logic        channel2_compare_out_o,
    input wire logic        channel2_complement_out_o,
    input wire logic        timer_b_extra_out_o,
    input wire logic        trap_state_o,
    input wire logic        irq_o
);
    logic [15:0] mod_q;
    logic [15:0] tctl_q;
    logic        wr_e;
    logic        acc_e;
    logic [5:0]  outs;
    logic [5:0]  exp_w;
    assign acc_e = psel_i && penable_i && pready_o;
    assign wr_e  = acc_e && pwrite_i;
    assign outs  = {channel2_complement_out_o, channel2_compare_out_o,
                    channel1_complement_out_o, channel1_compare_out_o,
                    channel0_complement_out_o, channel0_compare_out_o};
    assign exp_w = (mod_q[5:0] | mod_q[13:8] | {6{mod_q[7]}})
                 & (~mod_q[5:0] | timer_a_pattern_i) & (~mod_q[13:8] | timer_b_pattern_i)
                 & ({6{~mod_q[7]}} | multichannel_pattern_field_i);
    // ------------------------------------------------------------
    // shadows of the control words, reserved bits dropped
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            mod_q  <= 16'h0000;
            tctl_q <= 16'h0000;
        end else if (wr_e && paddr_i == `POMC_ADDR_MOD) begin
            mod_q <= pwdata_i[15:0] & 16'hBFBF;
        end else if (wr_e && paddr_i == `POMC_ADDR_TRAP) begin
            tctl_q <= pwdata_i[15:0] & 16'hFF07;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_mod_level: assert property (@(posedge clk_i) disable iff (rst_i)
        !trap_state_o && !$past(rst_i) |-> outs == $past(exp_w)) else $error("modulated level");
    a_xout_level: assert property (@(posedge clk_i) disable iff (rst_i)
        !trap_state_o && !$past(rst_i) |-> timer_b_extra_out_o == $past(mod_q[15] & timer_b_signal_i))
        else $error("extra output level");
    a_trap_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        !trap_input_pin_n_i && tctl_q[15] |-> ##2 trap_state_o) else $error("trap not entered");
    a_entry_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(trap_state_o) |-> $past(!trap_input_pin_n_i && tctl_q[15], 2))
        else $error("trap without pin");
    a_trap_force: assert property (@(posedge clk_i) disable iff (rst_i)
        trap_state_o && !$past(rst_i) |-> (outs & $past(tctl_q[13:8])) == 6'h00
        && !($past(tctl_q[14]) && timer_b_extra_out_o)) else $error("output not forced");
    a_exit_auto: assert property (@(posedge clk_i) disable iff (rst_i)
        (trap_state_o && tctl_q[15] && tctl_q[2:0] == 3'h3 && trap_input_pin_n_i)
        ##1 trap_input_pin_n_i [*2] |-> ##[0:2] !trap_state_o) else $error("no auto exit");
    a_exit_never: assert property (@(posedge clk_i) disable iff (rst_i)
        trap_state_o && tctl_q[1:0] == `POMC_SYNC_RSVD |=> trap_state_o) else $error("left trap");
    a_ready_next: assert property (@(posedge clk_i) disable iff (rst_i)
        psel_i && !penable_i |=> pready_o ##1 !pready_o) else $error("apb answer timing");
    a_mod_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_e && !pwrite_i && paddr_i == `POMC_ADDR_MOD |-> prdata_o == {16'h0000, mod_q})
        else $error("modulation readback");
    a_unmapped_err: assert property (@(posedge clk_i) disable iff (rst_i)
        acc_e && paddr_i > `POMC_ADDR_IRQ_MSK |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
        else $error("unmapped answer");
endmodule // pomc_top_monitor
bind pomc_top pomc_top_monitor u_mon (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .timer_a_pattern_i, .timer_b_pattern_i,
    .multichannel_pattern_field_i, .timer_b_signal_i, .timer_a_zero_match_i,
    .timer_b_zero_match_i, .trap_input_pin_n_i, .channel0_compare_out_o,
    .channel0_complement_out_o, .channel1_compare_out_o, .channel1_complement_out_o,
    .channel2_compare_out_o, .channel2_complement_out_o, .timer_b_extra_out_o,
    .trap_state_o, .irq_o);
`default_nettype wire

// ==== bench/pwm_output_modulation_control_tb_top.sv ====
// self-checking bench of the output modulation control block
`timescale 1ns/1ns
`default_nettype none
`include "pomc_defines.vh"
module pwm_output_modulation_control_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [5:0]  pa = 6'h00, pb = 6'h00, pm = 6'h00;
    logic        sig = 1'b0, za = 1'b0, zb = 1'b0, pull = 1'b0;
    wire  [31:0] prdata;
    wire         pready, pslverr, pin_n, xout, tstate, irq;
    wire  [5:0]  outs;
    logic [31:0] rd;
    logic        er;
    logic [15:0] m;
    int          errors = 0;
    int          checks_done = 0;
    always #5 clk_i = ~clk_i;
    pomc_top dut (.clk_i, .rst_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .timer_a_pattern_i(pa), .timer_b_pattern_i(pb),
        .multichannel_pattern_field_i(pm), .timer_b_signal_i(sig), .timer_a_zero_match_i(za),
        .timer_b_zero_match_i(zb), .trap_input_pin_n_i(pin_n),
        .channel0_compare_out_o(outs[0]), .channel0_complement_out_o(outs[1]),
        .channel1_compare_out_o(outs[2]), .channel1_complement_out_o(outs[3]),
        .channel2_compare_out_o(outs[4]), .channel2_complement_out_o(outs[5]),
        .timer_b_extra_out_o(xout), .trap_state_o(tstate), .irq_o(irq));
    pomc_stage_model u_stage (.clk_i, .pull_i(pull), .drive_i({xout, outs}),
        .trap_input_pin_n_o(pin_n));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic close_out;
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask
    // idle cycle first, so psel never gets two assignments in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            close_out();
        end
    endtask
    task automatic wait_state(input logic v);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (tstate !== v && n < 40);
        if (n >= 40) begin
            errors++;
            close_out();
        end
    endtask
    // all enabled sources must be high, none enabled gives low
    function automatic logic [5:0] exp_out(input logic [15:0] mm, input logic [5:0] a, b, c);
        return (mm[5:0] | mm[13:8] | {6{mm[7]}}) & (~mm[5:0] | a) & (~mm[13:8] | b)
             & ({6{~mm[7]}} | c);
    endfunction
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hAFEE56D7));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b1, `POMC_ADDR_MOD, 32'h0000FFFF);
        apb(1'b0, `POMC_ADDR_MOD, 32'h0);
        chk("reserved bits", 32'h0000BFBF, rd);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        for (int k = 0; k < 60; k++) begin
            m = 16'($urandom) & 16'hBFBF;
            if (k < 4)
                m = (k == 0) ? 16'h003F : (k == 1) ? 16'h3F00 : (k == 2) ? 16'h0080 : 16'h0000;
            apb(1'b1, `POMC_ADDR_MOD, {16'h0000, m});
            pa <= 6'($urandom);
            pb <= 6'($urandom);
            pm <= 6'($urandom);
            sig <= 1'($urandom);
            za <= 1'($urandom);
            zb <= 1'($urandom);
            repeat (3) @(posedge clk_i);
            chk("outputs", {26'h0, exp_out(m, pa, pb, pm)}, {26'h0, outs});
            chk("extra out", {31'h0, m[15] & sig}, {31'h0, xout});
        end
        apb(1'b1, `POMC_ADDR_IRQ_MSK, 32'h1);
        apb(1'b1, `POMC_ADDR_TRAP, 32'h0000FF03);
        apb(1'b1, `POMC_ADDR_MOD, 32'h0000BFBF);
        pa <= 6'h3F;
        pb <= 6'h3F;
        pm <= 6'h3F;
        sig <= 1'b1;
        pull <= 1'b1;
        wait_state(1'b1);
        repeat (2) @(posedge clk_i);
        chk("forced outputs", 32'h0, {25'h0, xout, outs});
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'b0, `POMC_ADDR_STAT, 32'h0);
        chk("trap status", 32'h3, rd);
        pull <= 1'b0;
        wait_state(1'b0);
        repeat (2) @(posedge clk_i);
        chk("released outputs", 32'h7F, {25'h0, xout, outs});
        apb(1'b0, `POMC_ADDR_IRQ_ST, 32'h0);
        chk("irq status", 32'h3, rd);
        apb(1'b1, `POMC_ADDR_IRQ_ST, 32'h3);
        apb(1'b0, `POMC_ADDR_IRQ_ST, 32'h0);
        chk("irq cleared", 32'h0, rd);
        chk("irq low", 32'h0, {31'h0, irq});
        apb(1'b1, `POMC_ADDR_TRAP, 32'h0000FF02);
        pull <= 1'b1;
        wait_state(1'b1);
        pull <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk("reserved sync holds", 32'h1, {31'h0, tstate});
        apb(1'b1, `POMC_ADDR_TRAP, 32'h0000FF03);
        wait_state(1'b0);
        za <= 1'b0;
        zb <= 1'b0;
        apb(1'b1, `POMC_ADDR_TRAP, 32'h00008504);
        pull <= 1'b1;
        wait_state(1'b1);
        repeat (2) @(posedge clk_i);
        chk("partial force", 32'h7A, {25'h0, xout, outs});
        pull <= 1'b0;
        za <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("software flag holds", 32'h1, {31'h0, tstate});
        za <= 1'b0;
        zb <= 1'b1;
        apb(1'b1, `POMC_ADDR_STAT, 32'h1);
        repeat (4) @(posedge clk_i);
        chk("sync awaited", 32'h1, {31'h0, tstate});
        zb <= 1'b0;
        za <= 1'b1;
        wait_state(1'b0);
        za <= 1'b0;
        apb(1'b1, `POMC_ADDR_TRAP, 32'h00007F03);
        pull <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk("pin disabled", 32'h0, {31'h0, tstate});
        pull <= 1'b0;
        close_out();
    end
endmodule // pwm_output_modulation_control_tb_top
`default_nettype wire
